// [hdl/nvc_pkg.sv]
package nvc_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_COMMAND_CONTROL     = 8'h00;
  localparam logic [7:0] OFF_READ_CONFIG_CONTROL = 8'h04;
  localparam logic [7:0] OFF_GEOMETRY_PARAMETERS = 8'h08;
  localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR    = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ENABLE_SET      = 8'h10;
  localparam logic [7:0] OFF_IRQ_FLAGS           = 8'h14;
  localparam logic [7:0] OFF_CONTROLLER_STATUS   = 8'h18;
  localparam logic [7:0] OFF_TARGET_LOCATION     = 8'h1c;
  localparam logic [7:0] OFF_REGION_LOCK_BITS    = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  EXECUTION_KEY          = 8'ha5;
  localparam logic [31:0] READ_CONFIG_RESET      = 32'h0000_0080;
  localparam logic [31:0] READ_CONFIG_MASK       = 32'h0007_039e;
  localparam int          IRQ_READY_BIT          = 0;
  localparam int          IRQ_ERROR_BIT          = 1;
  localparam int          ST_POWER_REDUCTION_BIT = 0;
  localparam int          ST_LOAD_BIT            = 1;
  localparam int          ST_PROG_ERROR_BIT      = 2;
  localparam int          ST_LOCK_ERROR_BIT      = 3;
  localparam int          ST_ARRAY_ERROR_BIT     = 4;
  localparam int          ST_SECURITY_BIT        = 8;
  localparam int          TARGET_WIDTH           = 22;

  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [6:0] CMD_ERASE_ROW        = 7'h02;
  localparam logic [6:0] CMD_WRITE_PAGE       = 7'h04;
  localparam logic [6:0] CMD_EMU_ERASE_ROW    = 7'h1a;
  localparam logic [6:0] CMD_EMU_WRITE_PAGE   = 7'h1c;
  localparam logic [6:0] CMD_LOCK_REGION      = 7'h40;
  localparam logic [6:0] CMD_UNLOCK_REGION    = 7'h41;
  localparam logic [6:0] CMD_SET_POWER_RED    = 7'h42;
  localparam logic [6:0] CMD_CLEAR_POWER_RED  = 7'h43;
  localparam logic [6:0] CMD_BUFFER_CLEAR     = 7'h44;
  localparam logic [6:0] CMD_SET_SECURITY     = 7'h45;
  localparam logic [6:0] CMD_CACHE_INVALIDATE = 7'h46;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PEND,
    ST_RUN
  } nvc_state_e;

  // Command handed to the flash array sequencer.
  typedef struct packed {
    logic        start;
    logic [6:0]  code;
    logic [22:0] byte_addr;
  } nvc_flash_cmd_s;

  // Completion report from the flash array sequencer.
  typedef struct packed {
    logic done;
    logic lock_err;
    logic array_err;
  } nvc_flash_rsp_s;

  // Read configuration fields driven to the read path and cache.
  typedef struct packed {
    logic       manual_write_select;
    logic [3:0] read_wait_states;
    logic [1:0] sleep_power_policy;
    logic [1:0] read_policy;
    logic       cache_off;
  } nvc_config_s;

endpackage

// [hdl/nvc_command_interface.sv]
module nvc_command_interface #(
  parameter logic [15:0] PAGE_COUNT      = 16'h0400,
  parameter logic [2:0]  PAGE_SIZE_CODE  = 3'h0,
  parameter logic [11:0] EMU_PAGE_COUNT  = 12'h000
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // APB register port
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Module state
  input  wire logic                    module_enable,
  output logic                         irq,
  // AHB flash access side
  input  wire logic                    ahb_access,
  input  wire logic                    ahb_wr_valid,
  input  wire logic [21:0]             ahb_wr_addr,
  output logic                         ahb_stall,
  // Flash array sequencer
  input  wire logic                    flash_busy,
  input  wire logic                    page_loaded,
  input  wire logic [15:0]             region_lock_bits,
  input  wire nvc_pkg::nvc_flash_rsp_s flash_rsp,
  output nvc_pkg::nvc_flash_cmd_s      flash_cmd,
  output nvc_pkg::nvc_config_s         config_out
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == nvc_pkg::OFF_COMMAND_CONTROL) || (w == nvc_pkg::OFF_READ_CONFIG_CONTROL) ||
           (w == nvc_pkg::OFF_GEOMETRY_PARAMETERS) || (w == nvc_pkg::OFF_IRQ_ENABLE_CLEAR) ||
           (w == nvc_pkg::OFF_IRQ_ENABLE_SET) || (w == nvc_pkg::OFF_IRQ_FLAGS) ||
           (w == nvc_pkg::OFF_CONTROLLER_STATUS) || (w == nvc_pkg::OFF_TARGET_LOCATION) ||
           (w == nvc_pkg::OFF_REGION_LOCK_BITS);
  endfunction

  function automatic logic is_known_cmd(input logic [6:0] c);
    return (c == nvc_pkg::CMD_ERASE_ROW) || (c == nvc_pkg::CMD_WRITE_PAGE) ||
           (c == nvc_pkg::CMD_EMU_ERASE_ROW) || (c == nvc_pkg::CMD_EMU_WRITE_PAGE) ||
           (c >= nvc_pkg::CMD_LOCK_REGION && c <= nvc_pkg::CMD_CACHE_INVALIDATE);
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  nvc_pkg::nvc_state_e     state_reg,      state_next;
  logic [6:0]              cmd_reg,        cmd_next;
  logic [7:0]              key_reg,        key_next;
  logic [31:0]             cfg_reg,        cfg_next;
  logic [1:0]              irq_en_reg,     irq_en_next;
  logic                    err_flag_reg,   err_flag_next;
  logic [21:0]             target_reg,     target_next;
  logic [31:0]             prdata_reg,     prdata_next;
  nvc_pkg::nvc_flash_cmd_s flash_cmd_reg,  flash_cmd_next;

  logic programming_error_flag_reg,   programming_error_flag_next;
  logic locked_region_error_flag_reg, locked_region_error_flag_next;
  logic array_error_flag_reg,         array_error_flag_next;
  logic power_reduction_flag_reg,     power_reduction_flag_next;
  logic security_set_flag_reg,        security_set_flag_next;

  logic        apb_wr;
  logic        apb_setup_rd;
  logic [7:0]  word_addr;
  logic        ready_flag;
  logic [31:0] cmd_word;
  logic [31:0] flags_word;
  logic [31:0] status_word;
  logic [31:0] geom_word;
  logic [31:0] target_word;
  logic [31:0] target_merged;

  assign apb_wr       = psel && penable && pwrite;
  assign apb_setup_rd = psel && !penable && !pwrite;
  assign word_addr    = {paddr[7:2], 2'b00};
  assign ready_flag   = (state_reg == nvc_pkg::ST_IDLE);

  // Key bit 0 shows a command still waiting to be handed to the array.
  assign cmd_word    = {16'h0000, key_reg, 1'b0, cmd_reg};
  assign flags_word  = {30'h0, err_flag_reg, ready_flag};
  assign status_word = {23'h0, security_set_flag_reg, 3'h0, array_error_flag_reg, locked_region_error_flag_reg,
                        programming_error_flag_reg, page_loaded, power_reduction_flag_reg};
  assign geom_word   = {EMU_PAGE_COUNT, 1'b0, PAGE_SIZE_CODE, PAGE_COUNT};
  assign target_word = {10'h000, target_reg};
  assign target_merged = merge_lanes(target_word, pwdata, pstrb);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    key_next       = key_reg;
    cfg_next       = cfg_reg;
    irq_en_next    = irq_en_reg;
    err_flag_next  = err_flag_reg;
    programming_error_flag_next   = programming_error_flag_reg;
    locked_region_error_flag_next = locked_region_error_flag_reg;
    array_error_flag_next         = array_error_flag_reg;
    power_reduction_flag_next     = power_reduction_flag_reg;
    security_set_flag_next        = security_set_flag_reg;
    target_next    = target_reg;
    prdata_next    = prdata_reg;
    flash_cmd_next = flash_cmd_reg;
    flash_cmd_next.start = 1'b0;

    // Register reads are captured in the setup phase so prdata is a flop.
    if (apb_setup_rd) begin
      case (word_addr)
        nvc_pkg::OFF_COMMAND_CONTROL:     prdata_next = cmd_word;
        nvc_pkg::OFF_READ_CONFIG_CONTROL: prdata_next = cfg_reg;
        nvc_pkg::OFF_GEOMETRY_PARAMETERS: prdata_next = geom_word;
        nvc_pkg::OFF_IRQ_ENABLE_CLEAR:    prdata_next = {30'h0, irq_en_reg};
        nvc_pkg::OFF_IRQ_ENABLE_SET:      prdata_next = {30'h0, irq_en_reg};
        nvc_pkg::OFF_IRQ_FLAGS:           prdata_next = flags_word;
        nvc_pkg::OFF_CONTROLLER_STATUS:   prdata_next = status_word;
        nvc_pkg::OFF_TARGET_LOCATION:     prdata_next = target_word;
        nvc_pkg::OFF_REGION_LOCK_BITS:    prdata_next = {16'h0000, region_lock_bits};
        default:                          prdata_next = 32'h0000_0000;
      endcase
    end

    // Clears by software come first so that a hardware set in the same
    // cycle, applied further down, is never lost.
    if (apb_wr) begin
      case (word_addr)
        nvc_pkg::OFF_COMMAND_CONTROL: begin
          if (pstrb[1]) begin
            if (pwdata[15:8] != nvc_pkg::EXECUTION_KEY) begin
              programming_error_flag_next = 1'b1;
            end else if (state_reg != nvc_pkg::ST_IDLE) begin
              programming_error_flag_next = 1'b1;
            end else begin
              // The code is taken from the same access as the key when lane 0 is strobed.
              if (pstrb[0]) begin
                cmd_next = pwdata[6:0];
              end
              key_next   = pwdata[15:8];
              state_next = nvc_pkg::ST_PEND;
            end
          end else if (pstrb[0]) begin
            cmd_next = pwdata[6:0];
          end
        end
        nvc_pkg::OFF_READ_CONFIG_CONTROL: begin
          if (!module_enable) begin
            cfg_next = merge_lanes(cfg_reg, pwdata, pstrb) & nvc_pkg::READ_CONFIG_MASK;
          end
        end
        nvc_pkg::OFF_IRQ_ENABLE_CLEAR: begin
          if (pstrb[0]) begin
            irq_en_next = irq_en_reg & ~pwdata[1:0];
          end
        end
        nvc_pkg::OFF_IRQ_ENABLE_SET: begin
          if (pstrb[0]) begin
            irq_en_next = irq_en_reg | pwdata[1:0];
          end
        end
        nvc_pkg::OFF_IRQ_FLAGS: begin
          if (pstrb[0] && pwdata[nvc_pkg::IRQ_ERROR_BIT]) begin
            err_flag_next = 1'b0;
          end
        end
        nvc_pkg::OFF_CONTROLLER_STATUS: begin
          if (pstrb[0]) begin
            programming_error_flag_next   = programming_error_flag_reg && !pwdata[nvc_pkg::ST_PROG_ERROR_BIT];
            locked_region_error_flag_next = locked_region_error_flag_reg && !pwdata[nvc_pkg::ST_LOCK_ERROR_BIT];
            array_error_flag_next         = array_error_flag_reg && !pwdata[nvc_pkg::ST_ARRAY_ERROR_BIT];
          end
        end
        nvc_pkg::OFF_TARGET_LOCATION: begin
          target_next = target_merged[21:0];
        end
        default: begin
        end
      endcase
    end

    // An AHB page-buffer write records its halfword address last, so it wins.
    if (ahb_wr_valid) begin
      target_next = ahb_wr_addr;
    end

    case (state_reg)
      nvc_pkg::ST_PEND: begin
        // Waiting out the array and the AHB port keeps AHB ahead.
        if (!ahb_access && !flash_busy) begin
          key_next = {key_reg[7:1], 1'b0};
          if (!is_known_cmd(cmd_reg)) begin
            programming_error_flag_next = 1'b1;
            state_next = nvc_pkg::ST_IDLE;
          end else begin
            flash_cmd_next.start     = 1'b1;
            flash_cmd_next.code      = cmd_reg;
            flash_cmd_next.byte_addr = {target_reg, 1'b0};
            state_next               = nvc_pkg::ST_RUN;
          end
        end
      end
      nvc_pkg::ST_RUN: begin
        if (flash_rsp.done) begin
          state_next = nvc_pkg::ST_IDLE;
          if (flash_rsp.lock_err) begin
            locked_region_error_flag_next = 1'b1;
          end
          if (flash_rsp.array_err) begin
            array_error_flag_next = 1'b1;
          end
          case (flash_cmd_reg.code)
            nvc_pkg::CMD_SET_POWER_RED:   power_reduction_flag_next = 1'b1;
            nvc_pkg::CMD_CLEAR_POWER_RED: power_reduction_flag_next = 1'b0;
            nvc_pkg::CMD_SET_SECURITY:    security_set_flag_next    = 1'b1;
            default: begin
            end
          endcase
        end
      end
      default: begin
      end
    endcase

    // Any status error flag going from 0 to 1 raises the sticky interrupt error flag.
    if ((programming_error_flag_next && !programming_error_flag_reg) ||
        (locked_region_error_flag_next && !locked_region_error_flag_reg) ||
        (array_error_flag_next && !array_error_flag_reg)) begin
      err_flag_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg     <= nvc_pkg::ST_IDLE;
      cmd_reg       <= 7'h00;
      key_reg       <= 8'h00;
      cfg_reg       <= nvc_pkg::READ_CONFIG_RESET;
      irq_en_reg    <= 2'h0;
      err_flag_reg  <= 1'b0;
      programming_error_flag_reg   <= 1'b0;
      locked_region_error_flag_reg <= 1'b0;
      array_error_flag_reg         <= 1'b0;
      power_reduction_flag_reg     <= 1'b0;
      security_set_flag_reg        <= 1'b0;
      target_reg    <= 22'h000000;
      prdata_reg    <= 32'h0000_0000;
      flash_cmd_reg <= '0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      key_reg       <= key_next;
      cfg_reg       <= cfg_next;
      irq_en_reg    <= irq_en_next;
      err_flag_reg  <= err_flag_next;
      programming_error_flag_reg   <= programming_error_flag_next;
      locked_region_error_flag_reg <= locked_region_error_flag_next;
      array_error_flag_reg         <= array_error_flag_next;
      power_reduction_flag_reg     <= power_reduction_flag_next;
      security_set_flag_reg        <= security_set_flag_next;
      target_reg    <= target_next;
      prdata_reg    <= prdata_next;
      flash_cmd_reg <= flash_cmd_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata    = prdata_reg;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !is_mapped(paddr);
  assign ahb_stall = (state_reg == nvc_pkg::ST_RUN);
  assign flash_cmd = flash_cmd_reg;
  assign irq       = (ready_flag && irq_en_reg[nvc_pkg::IRQ_READY_BIT]) ||
                     (err_flag_reg && irq_en_reg[nvc_pkg::IRQ_ERROR_BIT]);

  assign config_out.manual_write_select = cfg_reg[7];
  assign config_out.read_wait_states    = cfg_reg[4:1];
  assign config_out.sleep_power_policy  = cfg_reg[9:8];
  assign config_out.read_policy         = cfg_reg[17:16];
  assign config_out.cache_off           = cfg_reg[18];

endmodule

// [tb/nvc_command_interface_checker.sv]
module nvc_command_interface_checker (
  // Clock and reset
  input logic                    clk_sys,
  input logic                    resetn,
  // APB
  input logic                    psel,
  input logic                    penable,
  input logic [7:0]              paddr,
  input logic                    pready,
  input logic                    pslverr,
  // Flash side
  input logic                    ahb_access,
  input logic                    ahb_stall,
  input logic                    flash_busy,
  input nvc_pkg::nvc_flash_rsp_s flash_rsp,
  input nvc_pkg::nvc_flash_cmd_s flash_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence issue_s;
    flash_cmd.start ##1 !flash_cmd.start;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence

  start_pulse_a: assert property (flash_cmd.start |-> issue_s)
    else $error("start lasted more than one cycle");
  ahb_first_a: assert property (flash_cmd.start |-> !$past(ahb_access) && !$past(flash_busy))
    else $error("command started beside an AHB access or a busy array");
  busy_refuse_a: assert property (ahb_stall |=> !flash_cmd.start)
    else $error("second command started while one runs");
  stall_run_a: assert property (flash_cmd.start |-> ahb_stall)
    else $error("AHB not stalled when command starts");
  stall_hold_a: assert property (ahb_stall && !flash_rsp.done |=> ahb_stall)
    else $error("stall dropped before completion");
  stall_end_a: assert property (flash_rsp.done |=> !ahb_stall)
    else $error("stall kept after completion");
  halfword_addr_a: assert property (flash_cmd.start |-> !flash_cmd.byte_addr[0])
    else $error("byte address not halfword aligned");
  known_code_a: assert property (flash_cmd.start |->
    flash_cmd.code inside {7'h02, 7'h04, 7'h1a, 7'h1c, [7'h40:7'h46]})
    else $error("reserved code sent to the array");
  zero_wait_a: assert property (pready)
    else $error("ready low");
  err_phase_a: assert property (pslverr |-> access_s)
    else $error("error outside the access phase");
  unmapped_a: assert property (access_s ##0 (paddr[7:2] > 6'h08) |-> pslverr)
    else $error("unmapped access not flagged");
endmodule

bind nvc_command_interface nvc_command_interface_checker nvc_command_interface_checker_i (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .ahb_access(ahb_access), .ahb_stall(ahb_stall), .flash_busy(flash_busy),
  .flash_rsp(flash_rsp), .flash_cmd(flash_cmd));

// [tb/nvc_flash_model.sv]
module nvc_flash_model (
  // Clock and reset
  input  logic                    clk_sys,
  input  logic                    resetn,
  // Command and latency
  input  nvc_pkg::nvc_flash_cmd_s flash_cmd,
  input  logic [7:0]              lat,
  input  logic [1:0]              rsp_err,
  // Status
  output logic                    flash_busy,
  output nvc_pkg::nvc_flash_rsp_s flash_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;

  // Errors ride on the done pulse only, since the block trusts them nowhere else.
  always_ff @(posedge clk_sys) begin
    flash_rsp <= '0;
    if (!resetn) begin
      flash_busy <= 1'b0;
      cnt        <= 8'h00;
    end else if (flash_cmd.start) begin
      flash_busy <= 1'b1;
      cnt        <= lat;
    end else if (flash_busy && cnt == 8'h00) begin
      flash_busy     <= 1'b0;
      flash_rsp      <= {1'b1, rsp_err};
    end else if (flash_busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// [tb/tb_nvc_command_interface.sv]
module tb_nvc_command_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_sys, resetn, psel, penable, pwrite, pready, pslverr, rerr, seen;
  logic                    module_enable, irq, ahb_access, ahb_wr_valid, ahb_stall, flash_busy, page_loaded;
  logic [7:0]              paddr, lat;
  logic [31:0]             pwdata, prdata, rd;
  logic [3:0]              pstrb;
  logic [21:0]             ahb_wr_addr;
  logic [15:0]             region_lock_bits;
  logic [1:0]              rsp_err;
  logic [6:0]              got_code;
  logic [22:0]             got_addr;
  nvc_pkg::nvc_flash_rsp_s flash_rsp;
  nvc_pkg::nvc_flash_cmd_s flash_cmd;
  nvc_pkg::nvc_config_s    config_out;
  int                      n_mismatch, num_checks;
  logic [6:0]              codes [11] = '{7'h02, 7'h04, 7'h1a, 7'h1c, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44,
                                          7'h45, 7'h46};

  nvc_command_interface #(.PAGE_COUNT(16'h0100), .PAGE_SIZE_CODE(3'h3), .EMU_PAGE_COUNT(12'h020))
    nvc_command_interface_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .module_enable(module_enable), .irq(irq), .ahb_access(ahb_access),
    .ahb_wr_valid(ahb_wr_valid), .ahb_wr_addr(ahb_wr_addr), .ahb_stall(ahb_stall), .flash_busy(flash_busy),
    .page_loaded(page_loaded), .region_lock_bits(region_lock_bits), .flash_rsp(flash_rsp),
    .flash_cmd(flash_cmd), .config_out(config_out));
  nvc_flash_model nvc_flash_model_i (.clk_sys(clk_sys), .resetn(resetn), .flash_cmd(flash_cmd), .lat(lat),
    .rsp_err(rsp_err), .flash_busy(flash_busy), .flash_rsp(flash_rsp));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Data lines are inverted once released so a stale value cannot pass.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys) #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = w ? s : 4'h0;
    @(posedge clk_sys) #1;
    penable = 1'b1;
    @(posedge clk_sys);
    rd = prdata;
    rerr = pslverr;
    #1;
    psel = 1'b0;
    penable = 1'b0;
    pwdata = ~d;
  endtask
  task automatic issue(input logic [6:0] code, input logic [7:0] key);
    apb(1'b1, 8'h00, {16'h0000, key, 1'b0, code}, 4'h3);
  endtask
  task automatic await(input int n, input logic want);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge clk_sys) #1;
      seen = (flash_cmd.start === 1'b1);
      got_code = flash_cmd.code;
      got_addr = flash_cmd.byte_addr;
    end
    chk("start", {31'h0, seen}, {31'h0, want});
    if (want && !seen) wrap_up();
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, 8'h14, 32'h0, 4'h0);
      if (rd[0] === 1'b1) return;
    end
    n_mismatch++;
    wrap_up();
  endtask
  task automatic clear_err();
    apb(1'b1, 8'h18, 32'h1c, 4'h1);
    apb(1'b1, 8'h14, 32'h2, 4'h1);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("command_control", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("read_config_control", rd, 32'h80);
    apb(1'b0, 8'h08, 32'h0, 4'h0);
    chk("geometry_parameters", rd, 32'h02030100);
    apb(1'b0, 8'h14, 32'h0, 4'h0);
    chk("irq_flags", rd, 32'h1);
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("controller_status", rd, 32'h2);
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    chk("region_lock_bits", rd, 32'h5a3c);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_defer();
    @(posedge clk_sys) #1;
    ahb_wr_valid = 1'b1;
    ahb_access = 1'b1;
    @(posedge clk_sys) #1;
    ahb_wr_valid = 1'b0;
    issue(nvc_pkg::CMD_WRITE_PAGE, nvc_pkg::EXECUTION_KEY);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("key pending", rd, 32'ha504);
    apb(1'b0, 8'h14, 32'h0, 4'h0);
    chk("ready pending", rd, 32'h0);
    await(3, 1'b0);
    ahb_access = 1'b0;
    await(5, 1'b1);
    chk("code", {25'h0, got_code}, 32'h04);
    chk("byte_addr", {9'h0, got_addr}, 32'h200);
    chk("ahb_stall", {31'h0, ahb_stall}, 32'h1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("key issued", rd, 32'ha404);
    wait_ready();
  endtask
  task automatic t_bad_key();
    apb(1'b1, 8'h10, 32'h3, 4'h1);
    chk("irq ready", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h0c, 32'h1, 4'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    issue(nvc_pkg::CMD_ERASE_ROW, 8'h12);
    await(5, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("prog error", {31'h0, rd[2]}, 32'h1);
    chk("irq error", {31'h0, irq}, 32'h1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("discarded", rd, 32'ha404);
    clear_err();
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_busy();
    lat = 8'h28;
    rsp_err = 2'b11;
    issue(nvc_pkg::CMD_ERASE_ROW, nvc_pkg::EXECUTION_KEY);
    await(5, 1'b1);
    issue(nvc_pkg::CMD_BUFFER_CLEAR, nvc_pkg::EXECUTION_KEY);
    await(5, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("busy error", {31'h0, rd[2]}, 32'h1);
    clear_err();
    wait_ready();
    rsp_err = 2'b00;
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("array errors", rd, 32'h1a);
    chk("irq array error", {31'h0, irq}, 32'h1);
    clear_err();
    chk("irq errors cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_codes();
    lat = 8'h02;
    foreach (codes[i]) begin
      issue(codes[i], nvc_pkg::EXECUTION_KEY);
      await(6, 1'b1);
      chk("decoded code", {25'h0, got_code}, {25'h0, codes[i]});
      wait_ready();
      apb(1'b0, 8'h18, 32'h0, 4'h0);
      chk("mode bits", rd & 32'h101, {23'h0, codes[i] >= 7'h45, 7'h0, codes[i] == 7'h42});
    end
    issue(7'h03, nvc_pkg::EXECUTION_KEY);
    await(6, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("reserved error", {31'h0, rd[2]}, 32'h1);
    clear_err();
  endtask
  task automatic t_lanes();
    apb(1'b1, 8'h1c, 32'h11223344, 4'hf);
    apb(1'b0, 8'h1c, 32'h0, 4'h0);
    chk("target word", rd, 32'h00223344);
    apb(1'b1, 8'h1c, 32'h00aa0000, 4'h4);
    apb(1'b0, 8'h1c, 32'h0, 4'h0);
    chk("target byte", rd, 32'h002a3344);
    apb(1'b1, 8'h1c, 32'h00005566, 4'h3);
    apb(1'b0, 8'h1c, 32'h0, 4'h0);
    chk("target half", rd, 32'h002a5566);
    apb(1'b1, 8'h00, 32'h00000002, 4'h1);
    await(3, 1'b0);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("code lane", rd, 32'ha402);
    apb(1'b0, 8'h24, 32'h0, 4'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask
  task automatic t_protect();
    module_enable = 1'b1;
    apb(1'b1, 8'h04, 32'h1e, 4'hf);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("protected", rd, 32'h80);
    module_enable = 1'b0;
    apb(1'b1, 8'h04, 32'h80060193, 4'hf);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("unprotected", rd, 32'h00060192);
    chk("wait states", {28'h0, config_out.read_wait_states}, 32'h9);
    chk("config_out", {22'h0, config_out}, 32'h32d);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {resetn, psel, penable, pwrite, module_enable, ahb_access, ahb_wr_valid} = '0;
    {paddr, pwdata, pstrb} = '0;
    ahb_wr_addr = 22'h000100;
    region_lock_bits = 16'h5a3c;
    page_loaded = 1'b1;
    lat = 8'h14;
    rsp_err = 2'b00;
    repeat (4) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_reset();
    t_defer();
    t_bad_key();
    t_busy();
    t_codes();
    t_lanes();
    t_protect();
    wrap_up();
  end
endmodule
